/* File: rx_cfg_defines.svh */
`ifndef RX_CFG_DEFINES_SVH
`define RX_CFG_DEFINES_SVH
// Register select codes carried in the low four bits of each word.
`define SEL_RX_CLOCK      4'h3
`define SEL_DEMOD_SETUP   4'h4
`define SEL_SYNC_PATTERN  4'h5
`define SEL_CORR_SETUP    4'h6
`define SEL_TEST          4'hc
`define SEL_OFFSET_GAIN   4'hd
// Receive clock register fields.
`define DEMOD_DIV_HI      7
`define DEMOD_DIV_LO      4
`define CDR_DIV_HI        15
`define CDR_DIV_LO        8
`define SEQ_DIV_HI        31
`define SEQ_DIV_LO        16
`define RX_CLOCK_RESET    32'h0001_0113
// Demodulator setup fields.
`define DEMOD_TYPE_HI     5
`define DEMOD_TYPE_LO     4
`define POST_BW_HI        15
`define POST_BW_LO        6
`define LOCK_THR_HI       23
`define LOCK_THR_LO       16
`define LOCK_MODE_HI      25
`define LOCK_MODE_LO      23
`define LOCK_MODE_PIN_IN  3'h4
`define LOCK_MODE_TIMEOUT 3'h5
`define LOCK_MODE_SYNC_A  3'h2
`define LOCK_MODE_SYNC_B  3'h3
// Correlator setup fields.
`define LNA_REDUCED_BIT   15
`define DOT_PRODUCT_BIT   16
`define MIXER_LIN_BIT     17
`define RX_INVERT_BIT     18
`define FILTER_CAL_BIT    19
`define FILTER_DIV_HI     28
`define FILTER_DIV_LO     20
// Test register and offset/gain fields, sync hold count and top LNA gain code.
`define TEST_A_HI         17
`define TEST_A_LO         14
`define TEST_NO_OFFSET    4'h7
`define TEST_WITH_OFFSET  4'ha
`define OFFSET_HI         19
`define OFFSET_LO         4
`define GAIN_HI           23
`define GAIN_LO           20
`define OFFSET_SHIFT      12
`define SYNC_HOLD_BITS    4'h9
`define LNA_GAIN_TOP      2'h3
`endif

/* File: rx_cfg_pkg.sv */
package rx_cfg_pkg;
   // Demodulator type codes in register order.
   typedef enum logic [1:0] {demod_linear, demod_corr, demod_ask, demod_invalid} demod_type_t;
endpackage

/* File: rx_demod_config_regs.sv */
`include "rx_cfg_defines.svh"
// Behaviour
// R1: Words shift in MSB first on serial clock rises; latch on latch-enable rise.
// R2: Low four bits of the word select the destination register.
// R3: Select code 0110 writes the correlator/demodulator setup register.
// R4: Host keeps crystal over demod divider below 12 MHz FSK, 6 MHz ASK.
// R5: Host sets recovery divider near thirty-two times data rate within 2%.
// R6: Host sets sequencer clock near 100 kHz FSK, 40 kHz ASK.
// R7: Demod type 00 linear, 01 correlator, 10 ASK/OOK, 11 invalid.
// R8: Lock modes 0 to 3 drive the interrupt/lock pin as an output.
// R9: Lock mode 4 turns the pin into an input that locks the threshold.
// R10: Lock mode 5 locks after threshold setting sequencer clock periods.
// R11: Host uses modes 1, 3, 4 or 5 for runs longer than seven.
// R12: Host sets postdemod bandwidth from cutoff near 0.75 of data rate.
// R13: A 24-bit sync pattern is stored; detection active for modes 010, 011.
// R14: Pin rises on pattern match in receive, falls after nine more bits.
// R15: Transmitter sends sync pattern MSB first, LSB last.
// R16: Nine-bit filter divider is stored; each write with calibrate bit starts calibration.
// R17: Host keeps discriminator bandwidth at or below 600.
// R18: Reduced-gain bit forbids the top LNA gain setting.
// R19: Host disables AGC or powers ADC before voltage readbacks.
// R20: AFC valid in receive with linear or correlator; RSSI valid in receive.
// R21: Host keeps AGC thresholds more than 30 settings apart.
// R22: Host programs the AFC scaling coefficient from the crystal frequency.
// R23: Test output is second-order error-feedback sigma-delta of active filter output.
// R24: Sigma-delta runs on recovery clock ticks; filters on demodulator clock ticks.
// R25: Test mode 7 enables converter without offset, mode 10 with offset.
// R26: With offset, input is two to the gain times signal minus offset/4096.
// R27: Writes with an unimplemented select code change nothing.
module rx_demod_config_regs
   import rx_cfg_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        serial_clock,
   input  wire logic        serial_data_in,
   input  wire logic        serial_latch_enable,
   input  wire logic        rx_mode,
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic [15:0] linear_filter_out,
   input  wire logic [15:0] corr_filter_out,
   input  wire logic [1:0]  lna_gain_request,
   input  wire logic        int_lock_in,
   output logic             int_lock_out,
   output logic             int_lock_oe,
   output logic             demod_locked,
   output logic [1:0]       lna_gain,
   output logic             afc_valid,
   output logic             rssi_valid,
   output logic             filter_cal_start,
   output logic [8:0]       filter_clock_divider,
   output logic [1:0]       demod_type,
   output logic [9:0]       post_demod_bw,
   output logic             dot_product_select,
   output logic             mixer_linearity_bit,
   output logic             demod_tick,
   output logic             clock_output_pin
);
   logic [2:0]  sclk_q, sle_q;
   logic [1:0]  sdi_q, pin_q;
   logic [31:0] shift_q;
   logic [31:0] rx_clock_q, demod_setup_q, correlator_demod_setup_q, test_q, offset_gain_q;
   logic [23:0] sync_pattern_q, rx_hist_q;
   logic [3:0]  demod_cnt_q, sync_left_q;
   logic [7:0]  cdr_cnt_q, lock_cnt_q;
   logic [15:0] seq_cnt_q;
   logic        cdr_tick_q, seq_tick_q, sync_hit_q, timeout_lock_q;
   logic signed [19:0] err1_q, err2_q;

   // Serial pins pass two flip-flops; the third stage only feeds edge detection.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_q <= 3'h0;
         sle_q  <= 3'h0;
         sdi_q  <= 2'h0;
         pin_q  <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], serial_clock};
         sle_q  <= {sle_q[1:0], serial_latch_enable};
         sdi_q  <= {sdi_q[0], serial_data_in};
         pin_q  <= {pin_q[0], int_lock_in};
      end
   end

   wire       sclk_rise = sclk_q[1] & ~sclk_q[2];
   wire       latch     = sle_q[1] & ~sle_q[2];
   wire [3:0] sel       = shift_q[3:0];                                   // [R2]
   wire       wr_clock  = latch && (sel == `SEL_RX_CLOCK);
   wire       wr_demod  = latch && (sel == `SEL_DEMOD_SETUP);
   wire       wr_sync   = latch && (sel == `SEL_SYNC_PATTERN);
   wire       wr_corr   = latch && (sel == `SEL_CORR_SETUP);                // [R3]
   wire       wr_test   = latch && (sel == `SEL_TEST);
   wire       wr_offset = latch && (sel == `SEL_OFFSET_GAIN);

   // Shift register fills MSB first on each serial clock rise.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) shift_q <= 32'h0;
      else if (sclk_rise) shift_q <= {shift_q[30:0], sdi_q[1]};           // [R1]
   end

   // Latch the word into the selected register; other codes are dropped.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_clock_q               <= `RX_CLOCK_RESET;
         demod_setup_q            <= 32'h0;
         sync_pattern_q           <= 24'h0;
         correlator_demod_setup_q <= 32'h0;
         test_q                   <= 32'h0;
         offset_gain_q            <= 32'h0;
      end else begin
         if (wr_clock) rx_clock_q <= shift_q;                              // [R1]
         if (wr_demod) demod_setup_q <= shift_q;
         if (wr_sync) sync_pattern_q <= shift_q[31:8];                      // [R13]
         if (wr_corr) correlator_demod_setup_q <= shift_q;                  // [R3]
         if (wr_test) test_q <= shift_q;
         if (wr_offset) offset_gain_q <= shift_q;                           // [R27]
      end
   end

   // Field decode.
   wire [2:0]  lock_mode = demod_setup_q[`LOCK_MODE_HI:`LOCK_MODE_LO];
   wire [7:0]  lock_thr  = demod_setup_q[`LOCK_THR_HI:`LOCK_THR_LO];
   wire        sync_en   = (lock_mode == `LOCK_MODE_SYNC_A) || (lock_mode == `LOCK_MODE_SYNC_B);
   wire        pin_input = (lock_mode == `LOCK_MODE_PIN_IN);
   wire [3:0]  demod_div = rx_clock_q[`DEMOD_DIV_HI:`DEMOD_DIV_LO];
   wire [7:0]  cdr_div   = rx_clock_q[`CDR_DIV_HI:`CDR_DIV_LO];
   wire [15:0] seq_div   = rx_clock_q[`SEQ_DIV_HI:`SEQ_DIV_LO];
   wire        reduced   = correlator_demod_setup_q[`LNA_REDUCED_BIT];
   wire        rx_inv    = correlator_demod_setup_q[`RX_INVERT_BIT];
   wire [3:0]  test_a    = test_q[`TEST_A_HI:`TEST_A_LO];
   wire        dac_plain = (test_a == `TEST_NO_OFFSET);                      // [R25]
   wire        dac_offs  = (test_a == `TEST_WITH_OFFSET);                    // [R25]

   // Clock dividers: a zero divide value behaves as one.
   wire demod_end = (demod_cnt_q + 4'h1 >= demod_div);
   wire cdr_end   = (cdr_cnt_q + 8'h1 >= cdr_div);
   wire seq_end   = (seq_cnt_q + 16'h1 >= seq_div);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         demod_cnt_q <= 4'h0;
         cdr_cnt_q   <= 8'h0;
         seq_cnt_q   <= 16'h0;
         demod_tick  <= 1'b0;
         cdr_tick_q  <= 1'b0;
         seq_tick_q  <= 1'b0;
      end else begin
         demod_cnt_q <= demod_end ? 4'h0 : demod_cnt_q + 4'h1;
         seq_cnt_q   <= seq_end ? 16'h0 : seq_cnt_q + 16'h1;
         demod_tick  <= demod_end;                                           // [R24]
         seq_tick_q  <= seq_end;
         if (demod_end) cdr_cnt_q <= cdr_end ? 8'h0 : cdr_cnt_q + 8'h1;
         cdr_tick_q  <= demod_end && cdr_end;                                // [R24]
      end
   end

   // Timeout lock restarts on each demodulator setup write and counts sequencer ticks.
   // The count stops at the threshold, so a threshold of 255 cannot wrap to zero.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_cnt_q     <= 8'h0;
         timeout_lock_q <= 1'b0;
      end else if (wr_demod) begin
         lock_cnt_q     <= 8'h0;
         timeout_lock_q <= 1'b0;
      end else begin
         if (seq_tick_q && (lock_cnt_q < lock_thr)) lock_cnt_q <= lock_cnt_q + 8'h1;
         timeout_lock_q <= (lock_cnt_q >= lock_thr);                         // [R10]
      end
   end

   // Sync matcher on received bits; pin stays up for nine more bits.
   wire [23:0] hist_d = {rx_hist_q[22:0], rx_bit ^ rx_inv};
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_hist_q   <= 24'h0;
         sync_hit_q  <= 1'b0;
         sync_left_q <= 4'h0;
      end else if (rx_bit_valid) begin
         rx_hist_q <= hist_d;
         if (rx_mode && sync_en && (hist_d == sync_pattern_q)) begin       // [R14]
            sync_hit_q  <= 1'b1;
            sync_left_q <= `SYNC_HOLD_BITS;
         end else if (sync_left_q != 4'h0) begin
            sync_left_q <= sync_left_q - 4'h1;
            sync_hit_q  <= (sync_left_q != 4'h1);                            // [R14]
         end
      end
   end

   // Pin direction, lock state and validity flags.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_lock_oe      <= 1'b0;
         int_lock_out     <= 1'b0;
         demod_locked     <= 1'b0;
         lna_gain         <= 2'h0;
         afc_valid        <= 1'b0;
         rssi_valid       <= 1'b0;
         filter_cal_start <= 1'b0;
      end else begin
         int_lock_oe  <= !pin_input;                                         // [R8] [R9]
         int_lock_out <= sync_en ? sync_hit_q : demod_locked;                // [R8]
         if (pin_input) demod_locked <= pin_q[1];                            // [R9]
         else if (lock_mode == `LOCK_MODE_TIMEOUT) demod_locked <= timeout_lock_q; // [R10]
         else demod_locked <= 1'b0;
         lna_gain <= (reduced && lna_gain_request == `LNA_GAIN_TOP) ?
                     `LNA_GAIN_TOP - 2'h1 : lna_gain_request;                 // [R18]
         afc_valid  <= rx_mode && (demod_type == demod_linear || demod_type == demod_corr); // [R20]
         rssi_valid <= rx_mode;                                              // [R20]
         filter_cal_start <= wr_corr && shift_q[`FILTER_CAL_BIT];            // [R16]
      end
   end

   assign demod_type           = demod_setup_q[`DEMOD_TYPE_HI:`DEMOD_TYPE_LO];  // [R7]
   assign post_demod_bw        = demod_setup_q[`POST_BW_HI:`POST_BW_LO];
   assign filter_clock_divider = correlator_demod_setup_q[`FILTER_DIV_HI:`FILTER_DIV_LO]; // [R16]
   assign dot_product_select   = correlator_demod_setup_q[`DOT_PRODUCT_BIT];
   assign mixer_linearity_bit  = correlator_demod_setup_q[`MIXER_LIN_BIT];

   // Test converter input: active filter output, optional offset and gain.
   wire signed [15:0] filt_sel = (demod_type == demod_linear) ? linear_filter_out
                                                              : corr_filter_out; // [R23]
   wire signed [16:0] offs_val = {1'b0, offset_gain_q[`OFFSET_HI:`OFFSET_LO]} >>> `OFFSET_SHIFT;
   wire signed [16:0] diff_val = 17'(filt_sel) - offs_val;
   wire [3:0]         gain     = offset_gain_q[`GAIN_HI:`GAIN_LO];
   wire signed [15:0] dac_in   = dac_offs ? 16'(diff_val <<< gain) : filt_sel;  // [R26]
   wire signed [19:0] sd_v     = 20'(dac_in) + (err1_q <<< 1) - err2_q;       // [R23]
   wire signed [19:0] sd_y     = sd_v[19] ? -20'sd32768 : 20'sd32767;

   // Second-order error-feedback modulator stepped by recovery ticks.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err1_q           <= 20'sh0;
         err2_q           <= 20'sh0;
         clock_output_pin <= 1'b0;
      end else if (cdr_tick_q && (dac_plain || dac_offs)) begin            // [R24] [R25]
         err2_q           <= err1_q;
         err1_q           <= sd_v - sd_y;
         clock_output_pin <= !sd_v[19];                                      // [R23]
      end else if (!(dac_plain || dac_offs)) begin
         clock_output_pin <= 1'b0;
      end
   end

   sequence latch_seq;
      latch && (sel != `SEL_DEMOD_SETUP) && (sel != `SEL_CORR_SETUP);
   endsequence
   unmapped_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R27]
      latch && sel == 4'h0 |=> $stable(demod_setup_q) && $stable(correlator_demod_setup_q))
      else $error("Unmapped write changed a register.");
   corr_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)   // [R3]
      latch && sel == 4'h6 |=> correlator_demod_setup_q == $past(shift_q))
      else $error("Correlator setup not written.");
   demod_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)   // [R2]
      latch_seq |=> $stable(demod_setup_q))
      else $error("Demod setup written by another code.");
   pin_input_a: assert property (@(posedge sys_clk) disable iff (sys_rst)    // [R9]
      lock_mode == 3'h4 ##1 lock_mode == 3'h4 |-> !int_lock_oe)
      else $error("Pin driven in input mode.");
   pin_output_a: assert property (@(posedge sys_clk) disable iff (sys_rst)   // [R8]
      lock_mode < 3'h4 ##1 lock_mode < 3'h4 |-> int_lock_oe)
      else $error("Pin not driven in output mode.");
   sync_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)    // [R14]
      rx_bit_valid && sync_left_q == 4'h1 && !(rx_mode && sync_en && hist_d == sync_pattern_q)
      |=> !sync_hit_q)
      else $error("Sync flag held past nine bits.");
   lna_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)    // [R18]
      $past(reduced) |-> lna_gain != 2'h3)
      else $error("Top LNA gain selected in reduced mode.");
   afc_valid_a: assert property (@(posedge sys_clk) disable iff (sys_rst)    // [R20]
      ##1 afc_valid == $past(rx_mode && demod_type[1] == 1'b0))
      else $error("AFC valid flag wrong.");
   cal_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)    // [R16]
      wr_corr && shift_q[19] |=> filter_cal_start ##1 !filter_cal_start || wr_corr)
      else $error("Calibration start not pulsed.");
   timeout_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
      wr_demod && shift_q[25:23] == 3'h5 |=> ##1 !demod_locked)
      else $error("Lock held through a setup write.");
endmodule

/* File: host_serial_model.sv */
// Host side of the three-wire configuration port.
module host_serial_model (
   input  wire logic sys_clk,
   output logic      serial_clock,
   output logic      serial_data_in,
   output logic      serial_latch_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   // The serial clock stands low between frames.
   initial begin
      serial_clock = 1'b0;
      serial_data_in = 1'b0;
      serial_latch_enable = 1'b0;
   end

   // Shifts a word MSB first and then latches it.
   // Clock and latch levels are held four cycles and each data bit eight, since the pins are sampled through synchronisers.
   task automatic send_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         serial_data_in = w[i];
         repeat (4) @(negedge sys_clk);
         serial_clock = 1'b1;
         repeat (4) @(negedge sys_clk);
         serial_clock = 1'b0;
      end
      serial_data_in = ~w[0]; // The released line does not keep its last value.
      serial_latch_enable = 1'b1;
      repeat (4) @(negedge sys_clk);
      serial_latch_enable = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
endmodule

/* File: tb_top.sv */
`include "rx_cfg_defines.svh"
// Testbench for the receive configuration register bank.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        serial_clock, serial_data_in, serial_latch_enable;
   logic        rx_mode = 1'b0;
   logic        rx_bit = 1'b0;
   logic        rx_bit_valid = 1'b0;
   logic [1:0]  lna_gain_request = 2'h3;
   logic        int_lock_in = 1'b0;
   logic        int_lock_out, int_lock_oe, demod_locked, afc_valid, rssi_valid;
   logic        filter_cal_start, dot_product_select, mixer_linearity_bit;
   logic        demod_tick, clock_output_pin;
   logic [1:0]  lna_gain, demod_type;
   logic [8:0]  filter_clock_divider;
   logic [9:0]  post_demod_bw;
   int          fail_count = 0;
   int          comparisons = 0;
   int          cal_pulses = 0;
   int          sd_ones = 0;
   int          ticks = 0;
   int          cycles = 0;
   logic [23:0] pattern = 24'hd3a51c;

   // The clock runs at 25 MHz.
   always #20 sys_clk = ~sys_clk;

   host_serial_model i_host_serial_model (.sys_clk(sys_clk), .serial_clock(serial_clock),
      .serial_data_in(serial_data_in), .serial_latch_enable(serial_latch_enable));

   rx_demod_config_regs i_rx_demod_config_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .serial_latch_enable(serial_latch_enable), .rx_mode(rx_mode), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .linear_filter_out(16'h1234), .corr_filter_out(16'hedcc),
      .lna_gain_request(lna_gain_request), .int_lock_in(int_lock_in),
      .int_lock_out(int_lock_out), .int_lock_oe(int_lock_oe), .demod_locked(demod_locked),
      .lna_gain(lna_gain), .afc_valid(afc_valid), .rssi_valid(rssi_valid),
      .filter_cal_start(filter_cal_start), .filter_clock_divider(filter_clock_divider),
      .demod_type(demod_type), .post_demod_bw(post_demod_bw),
      .dot_product_select(dot_product_select), .mixer_linearity_bit(mixer_linearity_bit),
      .demod_tick(demod_tick), .clock_output_pin(clock_output_pin));

   // Counts calibration pulses, converter ones and divider ticks, and cuts a hung run short.
   always @(posedge sys_clk) begin
      cycles++;
      if (filter_cal_start === 1'b1) cal_pulses++;
      if (clock_output_pin === 1'b1) sd_ones++;
      if (demod_tick === 1'b1) ticks++;
      if (cycles == 10000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // Writes the demodulator setup word; bit 23 is shared by lock mode and threshold.
   task automatic wr_demod(input logic [2:0] md, input logic [6:0] thr,
                           input logic [9:0] bw, input logic [1:0] ty);
      i_host_serial_model.send_word({6'h0, md, thr, bw, ty, `SEL_DEMOD_SETUP});
   endtask

   // Presents one recovered bit with its single-cycle strobe.
   task automatic send_rx(input logic b);
      rx_bit = b;
      rx_bit_valid = 1'b1;
      cyc(1);
      rx_bit_valid = 1'b0;
      cyc(3);
   endtask

   // Main sequence of scenarios.
   initial begin
      cyc(4);
      sys_rst = 1'b0;
      cyc(2);
      `CHK("oe_mode0", 1'b1, int_lock_oe)
      rx_mode = 1'b1;
      for (int t = 0; t < 4; t++) begin
         wr_demod(3'h0, 7'h00, 10'h2a5 + 10'(t), 2'(t));
         `CHK("demod_type", 2'(t), demod_type)
         `CHK("post_bw", 10'h2a5 + 10'(t), post_demod_bw)
         `CHK("afc_valid", (t < 2) ? 1'b1 : 1'b0, afc_valid)
         `CHK("rssi_valid", 1'b1, rssi_valid)
      end
      rx_mode = 1'b0;
      cyc(3);
      `CHK("afc_tx", 1'b0, afc_valid)
      `CHK("rssi_tx", 1'b0, rssi_valid)
      i_host_serial_model.send_word({3'h0, 9'h1ff, 5'b10111, 11'h0, `SEL_CORR_SETUP});
      `CHK("filter_div", 9'h1ff, filter_clock_divider)
      `CHK("dot_product", 1'b1, dot_product_select)
      `CHK("mixer_lin", 1'b1, mixer_linearity_bit)
      `CHK("cal_pulses", 1, cal_pulses)
      `CHK("lna_reduced", 2'h2, lna_gain)
      i_host_serial_model.send_word({3'h0, 9'h001, 5'b10000, 11'h0, `SEL_CORR_SETUP});
      `CHK("cal_pulses2", 2, cal_pulses)
      `CHK("lna_full", 2'h3, lna_gain)
      `CHK("dot_cleared", 1'b0, dot_product_select)
      // The host never reads back, so it owes no AGC, AFC or ADC setup.
      i_host_serial_model.send_word(32'hffff_fff7);
      i_host_serial_model.send_word(32'hffff_fff0);
      `CHK("unmapped_type", 2'h3, demod_type)
      `CHK("unmapped_div", 9'h001, filter_clock_divider)
      `CHK("unmapped_cal", 2, cal_pulses)
      wr_demod(3'h4, 7'h00, 10'h000, 2'h1);
      int_lock_in = 1'b1;
      cyc(6);
      `CHK("oe_mode4", 1'b0, int_lock_oe)
      `CHK("pin_lock", 1'b1, demod_locked)
      int_lock_in = 1'b0;
      cyc(6);
      `CHK("pin_unlock", 1'b0, demod_locked)
      // Mode 5 forces the threshold's top bit, giving 128 sequencer ticks.
      wr_demod(3'h5, 7'h00, 10'h000, 2'h1);
      `CHK("lock_early", 1'b0, demod_locked)
      cyc(150);
      `CHK("lock_timeout", 1'b1, demod_locked)
      `CHK("oe_mode5", 1'b1, int_lock_oe)
      i_host_serial_model.send_word({pattern, 4'h0, `SEL_SYNC_PATTERN});
      wr_demod(3'h3, 7'h00, 10'h000, 2'h1);
      rx_mode = 1'b1;
      for (int i = 23; i >= 0; i--) send_rx(pattern[i]);
      `CHK("sync_rise", 1'b1, int_lock_out)
      for (int i = 0; i < 8; i++) send_rx(1'b0);
      `CHK("sync_hold", 1'b1, int_lock_out)
      send_rx(1'b0);
      `CHK("sync_fall", 1'b0, int_lock_out)
      // Test converter on the correlator output, then the linear one, then with gain.
      `CHK("dac_off", 1'b0, clock_output_pin)
      i_host_serial_model.send_word(32'h0001_c00c);
      sd_ones = 0;
      cyc(256);
      `CHK("dac_corr", 1'b1, sd_ones > 103 && sd_ones < 117)
      wr_demod(3'h0, 7'h00, 10'h000, 2'h0);
      sd_ones = 0;
      cyc(256);
      `CHK("dac_linear", 1'b1, sd_ones > 139 && sd_ones < 153)
      i_host_serial_model.send_word(32'h0002_800c);
      i_host_serial_model.send_word(32'h0010_000d);
      sd_ones = 0;
      cyc(256);
      `CHK("dac_gain", 1'b1, sd_ones > 157 && sd_ones < 172)
      i_host_serial_model.send_word(32'h0000_000c);
      `CHK("dac_stop", 1'b0, clock_output_pin)
      // Demodulator clock 6.25 MHz, recovery at half of it, sequencer at 100 kHz.
      i_host_serial_model.send_word({16'h00fa, 8'h02, 4'h4, `SEL_RX_CLOCK});
      ticks = 0;
      cyc(40);
      `CHK("demod_ticks", 10, ticks)
      final_report();
   end
endmodule
